//--- dv/mcuic_core_model.sv
// core sequencer stand-in: counts vectors and returns from the isr on request
`default_nettype none
module mcuic_core_model (
   // clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // controller side
   input  wire logic                          vector_load,
   input  wire logic                          push_return,
   input  wire logic [mcuic_pkg::PC_WIDTH-1:0] vector_addr,
   output var  logic                          return_from_isr,
   // bench side
   input  wire logic                          ret_go,
   input  wire logic [3:0]                    ret_dly,
   output var  int                            vec_cnt,
   output var  int                            bad_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_q;
   // return is answered after a bench-chosen delay, from prompt to slow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q          <= 0;
         return_from_isr <= 1'h0;
         vec_cnt         <= 0;
         bad_cnt         <= 0;
      end else begin
         return_from_isr <= (wait_q == 1);
         if (ret_go) begin
            wait_q <= int'(ret_dly) + 1;
         end else if (wait_q != 0) begin
            wait_q <= wait_q - 1;
         end
         if (vector_load === 1'h1) begin
            vec_cnt <= vec_cnt + 1;
            if (push_return !== 1'h1 || vector_addr !== mcuic_pkg::VECTOR_ADDR) begin
               bad_cnt <= bad_cnt + 1;
            end
         end
      end
   end
endmodule // mcuic_core_model
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the interrupt controller
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {string nm; logic [31:0] d; logic er;} mcuic_note_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_irq_pin;
   logic        timer_rollover, nvm_write_done, return_from_isr, sleep_enter, ret_go;
   logic        irq_request, vector_load, push_return, wake_up, sleeping;
   logic [11:0] paddr, fa;
   logic [31:0] pwdata, prdata, rnd;
   logic [3:0]  port_b_pins, ret_dly;
   logic [12:0] vector_addr;
   logic [7:0]  en[4], fl[4], ic;
   int          err_total, n_compared, vec_cnt, bad_cnt, wake_cnt, seed, n, v0;
   mcuic_note_t notes[$];

   mcuic_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_irq_pin(ext_irq_pin), .port_b_pins(port_b_pins), .timer_rollover(timer_rollover),
      .nvm_write_done(nvm_write_done), .return_from_isr(return_from_isr), .sleep_enter(sleep_enter),
      .irq_request(irq_request), .vector_load(vector_load), .push_return(push_return),
      .vector_addr(vector_addr), .wake_up(wake_up), .sleeping(sleeping));
   mcuic_core_model i_core (.pclk(pclk), .presetn(presetn), .vector_load(vector_load),
      .push_return(push_return), .vector_addr(vector_addr), .return_from_isr(return_from_isr),
      .ret_go(ret_go), .ret_dly(ret_dly), .vec_cnt(vec_cnt), .bad_cnt(bad_cnt));

   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm, input logic er);
      notes.push_back('{nm, e, er});
      apb(1'h0, a, 32'h0);
   endtask
   task automatic vec(input logic yes, input int lim, input string nm);
      int b;
      b = vec_cnt;
      repeat (lim) @(posedge pclk);
      chk(nm, 32'(yes), 32'(vec_cnt > b));
   endtask
   task automatic evt(input int s);
      @(posedge pclk);
      case (s)
         0: timer_rollover <= 1'h1;
         1: nvm_write_done <= 1'h1;
         2: ext_irq_pin <= 1'h1;
         default: port_b_pins[3] <= ~port_b_pins[3];
      endcase
      @(posedge pclk);
      timer_rollover <= 1'h0;
      nvm_write_done <= 1'h0;
      repeat (3) @(posedge pclk);
      ext_irq_pin <= 1'h0;
   endtask
   task automatic ret;
      @(posedge pclk);
      ret_go <= 1'h1;
      ret_dly <= 4'($random(seed));
      @(posedge pclk);
      ret_go <= 1'h0;
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // read checker: oldest note against each completed read
   always @(posedge pclk) begin
      if (presetn === 1'h1 && psel && penable && pready === 1'h1 && !pwrite && notes.size() > 0) begin
         chk({notes[0].nm, " data"}, notes[0].d, prdata);
         chk({notes[0].nm, " error"}, 32'(notes[0].er), 32'(pslverr));
         void'(notes.pop_front());
      end
      if (wake_up === 1'h1) wake_cnt++;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      end_sim();
   end
   initial begin
      seed = 94;
      {presetn, psel, penable, pwrite, ext_irq_pin, timer_rollover, nvm_write_done} = 7'h00;
      {sleep_enter, ret_go, ret_dly, port_b_pins, paddr, pwdata} = 54'h0;
      en = '{8'h20, 8'h40, 8'h10, 8'h08};
      fl = '{8'h04, 8'h10, 8'h02, 8'h01};
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      rd(mcuic_pkg::INTCTL_OFF, 32'h00, "control reset", 1'h0);
      rd(mcuic_pkg::OPTION_OFF, 32'hFF, "option reset", 1'h0);
      rd(mcuic_pkg::NVMCTL_OFF, 32'h00, "nvm reset", 1'h0);
      rd(12'h010, 32'h00, "unmapped", 1'h1);
      $display("test reset done");
      for (int s = 0; s < 4; s++) begin
         fa = (s == 1) ? mcuic_pkg::NVMCTL_OFF : mcuic_pkg::INTCTL_OFF;
         ic = (s == 1) ? 8'h00 : fl[s];
         apb(1'h1, mcuic_pkg::INTCTL_OFF, 32'h80);
         evt(s);
         vec(1'h0, 6, "masked source");
         rd(fa, {24'h0, fl[s] | ((s == 1) ? 8'h00 : 8'h80)}, "flag set", 1'h0);
         apb(1'h1, mcuic_pkg::INTCTL_OFF, {24'h0, en[s] | ic});
         repeat (2) @(posedge pclk);
         chk("request gated", 32'h0, 32'(irq_request));
         apb(1'h1, mcuic_pkg::INTCTL_OFF, {24'h0, 8'h80 | en[s] | ic});
         vec(1'h1, 6, "vector taken");
         rd(mcuic_pkg::INTCTL_OFF, {24'h0, en[s] | ic}, "entry clears enable", 1'h0);
         ret();
         vec(1'h1, 24, "flag re-raises");
         apb(1'h1, mcuic_pkg::INTCTL_OFF, {24'h0, en[s]});
         apb(1'h1, mcuic_pkg::NVMCTL_OFF, 32'h0);
         ret();
         repeat (20) @(posedge pclk);
         rd(mcuic_pkg::INTCTL_OFF, {24'h0, 8'h80 | en[s]}, "return sets enable", 1'h0);
         apb(1'h1, mcuic_pkg::INTCTL_OFF, 32'h0);
         $display("test source %0d done", s);
      end
      for (int s = 2; s < 4; s++) begin
         apb(1'h1, mcuic_pkg::INTCTL_OFF, {24'h0, 8'h80 | en[s]});
         v0 = vec_cnt;
         n = 0;
         fork
            evt(s);
         join_none
         while (vec_cnt == v0 && n < 12) begin
            @(posedge pclk);
            n++;
         end
         // bench adds drive edge and vector count register to the 3 to 4 cycles
         chk("pin latency", 32'h1, 32'(n >= 5 && n <= 8));
         repeat (6) @(posedge pclk);
         apb(1'h1, mcuic_pkg::INTCTL_OFF, 32'h0);
      end
      $display("test latency done");
      apb(1'h1, mcuic_pkg::OPTION_OFF, 32'hBF);
      apb(1'h1, mcuic_pkg::INTCTL_OFF, 32'h0);
      ext_irq_pin <= 1'h1;
      repeat (6) @(posedge pclk);
      rd(mcuic_pkg::INTCTL_OFF, 32'h00, "rising ignored", 1'h0);
      ext_irq_pin <= 1'h0;
      repeat (6) @(posedge pclk);
      rd(mcuic_pkg::INTCTL_OFF, 32'h02, "falling taken", 1'h0);
      rnd = $random(seed);
      rnd = {24'h0, rnd[7], 1'h1, rnd[5:0]};
      apb(1'h1, mcuic_pkg::OPTION_OFF, rnd);
      rd(mcuic_pkg::OPTION_OFF, rnd, "option readback", 1'h0);
      apb(1'h1, mcuic_pkg::INTCTL_OFF, 32'h20);
      $display("test edge select done");
      apb(1'h1, mcuic_pkg::NVMCTL_OFF, 32'h0);
      sleep_enter <= 1'h1;
      @(posedge pclk);
      sleep_enter <= 1'h0;
      repeat (2) @(posedge pclk);
      chk("asleep", 32'h1, 32'(sleeping));
      evt(2);
      chk("disabled pin keeps sleep", 32'h1, 32'(sleeping));
      v0 = wake_cnt;
      evt(0);
      chk("enabled source wakes", 32'h1, 32'(wake_cnt - v0));
      chk("awake", 32'h0, 32'(sleeping));
      vec(1'h0, 4, "no vector with global clear");
      apb(1'h1, mcuic_pkg::INTCTL_OFF, 32'h90);
      sleep_enter <= 1'h1;
      @(posedge pclk);
      sleep_enter <= 1'h0;
      fork
         evt(2);
      join_none
      vec(1'h1, 12, "vector after wake");
      $display("test sleep done");
      apb(1'h1, mcuic_pkg::INTCTL_OFF, 32'h80);
      repeat (4) @(posedge pclk);
      // the core model clears its counters in reset, so look before it
      chk("vector pushes and loads 0004h", 32'h0, 32'(bad_cnt));
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      rd(mcuic_pkg::INTCTL_OFF, 32'h00, "reset clears enable", 1'h0);
      repeat (4) @(posedge pclk);
      $display("test mid reset done");
      end_sim();
   end
endmodule // testbench
`default_nettype wire

//--- rtl/mcuic_evt_if.sv
// event signals between the pin synchroniser and the controller
`default_nettype none
interface mcuic_evt_if;
   logic       edge_sel;
   logic       ext_edge;
   logic       port_change;
   logic [3:0] port_now;
   modport det (input edge_sel, output ext_edge, output port_change, output port_now);
   modport ctl (output edge_sel, input ext_edge, input port_change, input port_now);
endinterface : mcuic_evt_if
`default_nettype wire

//--- rtl/mcuic_pin_sync.sv
// pin synchronisers and edge / change detectors
`default_nettype none
module mcuic_pin_sync #(
   parameter int PORT_W = 4
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // pins
   input  wire logic              ext_irq_pin,
   input  wire logic [PORT_W-1:0] port_b_pins,
   // detected events
   mcuic_evt_if.det               evt
);
   logic              ext_s1_q, ext_s2_q, ext_s3_q;
   logic [PORT_W-1:0] port_s1_q, port_s2_q, port_s3_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1_q  <= 1'b0;
         ext_s2_q  <= 1'b0;
         ext_s3_q  <= 1'b0;
         port_s1_q <= '0;
         port_s2_q <= '0;
         port_s3_q <= '0;
      end else begin
         ext_s1_q  <= ext_irq_pin;
         ext_s2_q  <= ext_s1_q;
         ext_s3_q  <= ext_s2_q;
         port_s1_q <= port_b_pins;
         port_s2_q <= port_s1_q;
         port_s3_q <= port_s2_q;
      end
   end

   assign evt.ext_edge    = evt.edge_sel ? (ext_s2_q & ~ext_s3_q) : (~ext_s2_q & ext_s3_q);
   assign evt.port_change = |(port_s2_q ^ port_s3_q);
   assign evt.port_now    = port_s2_q;
endmodule // mcuic_pin_sync
`default_nettype wire

//--- rtl/mcuic_pkg.sv
// constants and types shared by the interrupt controller files
`default_nettype none
package mcuic_pkg;
   // register byte offsets on the apb slave
   localparam logic [11:0] INTCTL_OFF = 12'h000;
   localparam logic [11:0] OPTION_OFF = 12'h004;
   localparam logic [11:0] NVMCTL_OFF = 12'h008;
   localparam logic [11:0] STATUS_OFF = 12'h00C;
   // interrupt_control fields
   localparam int GIE_BIT       = 7;
   localparam int NVM_EN_BIT    = 6;
   localparam int TMR_EN_BIT    = 5;
   localparam int EXT_EN_BIT    = 4;
   localparam int PORT_EN_BIT   = 3;
   localparam int TMR_FLAG_BIT  = 2;
   localparam int EXT_FLAG_BIT  = 1;
   localparam int PORT_FLAG_BIT = 0;
   // option and nvm_control fields
   localparam int EDGE_SEL_BIT  = 6;
   localparam int NVM_FLAG_BIT  = 4;
   // status fields
   localparam int STAT_REQ_BIT   = 0;
   localparam int STAT_SLEEP_BIT = 1;
   localparam int STAT_ISR_BIT   = 2;
   localparam int STAT_PINS_LSB  = 4;
   // reset values
   localparam logic [7:0] INTCTL_RST = 8'h00;
   localparam logic [7:0] OPTION_RST = 8'hFF;
   localparam logic [7:0] NVMCTL_RST = 8'h00;
   // core side
   localparam int          PC_WIDTH    = 13;
   localparam logic [12:0] VECTOR_ADDR = 13'h0004;
   localparam int          NUM_SOURCES = 4;
   localparam int          LATENCY_MIN = 3;
   localparam int          LATENCY_MAX = 4;
   typedef enum logic {
      MCUIC_RUN   = 1'b0,
      MCUIC_SLEEP = 1'b1
   } mcuic_pwr_t;
endpackage : mcuic_pkg
`default_nettype wire

//--- rtl/mcuic_top.sv
// interrupt controller with apb registers, four sources and sleep wake-up
//
// What this block does
// - four sources: pin, timer, port, nvm
// - global enable gates every request
// - each source has own enable
// - reset clears global enable
// - return from isr sets global enable
// - accept: clear enable, push, vector 0004h
// - pin and port latency three-four cycles
// - flags stay set until software clears
// - pin edge polarity chosen by select bit
// - selected pin edge sets pin flag
// - pin enable at control bit four
// - pin wakes sleep only when enabled
// - timer rollover sets flag bit two
// - any port pin change sets flag bit zero
// - nvm write done sets nvm flag
// - only return address saved on entry
// - enabled source wakes regardless of global
`default_nettype none
module mcuic_top #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [ADDR_W-1:0]            paddr,
   input  wire logic [31:0]                  pwdata,
   output var  logic [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // device pins
   input  wire logic                         ext_irq_pin,
   input  wire logic [3:0]                   port_b_pins,
   // peripheral events, one-cycle pulses
   input  wire logic                         timer_rollover,
   input  wire logic                         nvm_write_done,
   // core sequencer
   input  wire logic                         return_from_isr,
   input  wire logic                         sleep_enter,
   output logic                              irq_request,
   output logic                              vector_load,
   output logic                              push_return,
   output logic [mcuic_pkg::PC_WIDTH-1:0]    vector_addr,
   output logic                              wake_up,
   output logic                              sleeping
);
   ////////////////////////////////////////////////////////////////////////////
   mcuic_evt_if evt ();

   mcuic_pin_sync #(.PORT_W(4)) u_sync (
      .pclk        (pclk),
      .presetn     (presetn),
      .ext_irq_pin (ext_irq_pin),
      .port_b_pins (port_b_pins),
      .evt         (evt.det)
   );

   logic [7:0]           intctl_q, intctl_d;
   logic [7:0]           option_q;
   logic                 nvm_flag_q, nvm_flag_d;
   logic                 vec_q;
   logic                 wake_q;
   logic                 in_isr_q;
   logic [31:0]          rdata_q;
   mcuic_pkg::mcuic_pwr_t pwr_q;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states, read data captured in the setup cycle
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   wire setup_w    = psel & ~penable;
   wire wr_w       = psel & penable & pwrite;
   wire hit_int_w  = hit(paddr, mcuic_pkg::INTCTL_OFF);
   wire hit_opt_w  = hit(paddr, mcuic_pkg::OPTION_OFF);
   wire hit_nvm_w  = hit(paddr, mcuic_pkg::NVMCTL_OFF);
   wire hit_sta_w  = hit(paddr, mcuic_pkg::STATUS_OFF);
   wire mapped_w   = hit_int_w | hit_opt_w | hit_nvm_w | hit_sta_w;
   wire wr_int_w   = wr_w & hit_int_w;
   wire wr_opt_w   = wr_w & hit_opt_w;
   wire wr_nvm_w   = wr_w & hit_nvm_w;

   // every register is a plain flop, so no wait state is ever needed
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped_w;
   assign prdata  = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // source flags and enables
   wire gie_w      = intctl_q[mcuic_pkg::GIE_BIT];
   wire [3:0] flags_w = {nvm_flag_q, intctl_q[mcuic_pkg::TMR_FLAG_BIT],
                         intctl_q[mcuic_pkg::EXT_FLAG_BIT], intctl_q[mcuic_pkg::PORT_FLAG_BIT]};
   wire [3:0] enables_w = {intctl_q[mcuic_pkg::NVM_EN_BIT], intctl_q[mcuic_pkg::TMR_EN_BIT],
                           intctl_q[mcuic_pkg::EXT_EN_BIT], intctl_q[mcuic_pkg::PORT_EN_BIT]};
   wire pending_w  = |(flags_w & enables_w);
   wire req_w      = gie_w & pending_w;
   // core takes the vector only while running; in sleep it wakes first
   wire accept_w   = req_w & (pwr_q == mcuic_pkg::MCUIC_RUN) & ~vec_q;

   assign evt.edge_sel = option_q[mcuic_pkg::EDGE_SEL_BIT];

   // hardware sets beat software clears in the same cycle
   always_comb begin
      intctl_d = wr_int_w ? pwdata[7:0] : intctl_q;
      if (evt.ext_edge) begin
         intctl_d[mcuic_pkg::EXT_FLAG_BIT] = 1'b1;
      end
      if (timer_rollover) begin
         intctl_d[mcuic_pkg::TMR_FLAG_BIT] = 1'b1;
      end
      if (evt.port_change) begin
         intctl_d[mcuic_pkg::PORT_FLAG_BIT] = 1'b1;
      end
      if (return_from_isr) begin
         intctl_d[mcuic_pkg::GIE_BIT] = 1'b1;
      end
      if (accept_w) begin
         intctl_d[mcuic_pkg::GIE_BIT] = 1'b0;
      end
   end

   assign nvm_flag_d = nvm_write_done | (wr_nvm_w ? pwdata[mcuic_pkg::NVM_FLAG_BIT] : nvm_flag_q);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         intctl_q   <= mcuic_pkg::INTCTL_RST;
         option_q   <= mcuic_pkg::OPTION_RST;
         nvm_flag_q <= mcuic_pkg::NVMCTL_RST[mcuic_pkg::NVM_FLAG_BIT];
      end else begin
         intctl_q   <= intctl_d;
         nvm_flag_q <= nvm_flag_d;
         if (wr_opt_w) begin
            option_q <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (setup_w) begin
         rdata_q <= 32'h0000_0000;
         if (hit_int_w) rdata_q[7:0] <= intctl_q;
         if (hit_opt_w) rdata_q[7:0] <= option_q;
         if (hit_nvm_w) rdata_q[mcuic_pkg::NVM_FLAG_BIT] <= nvm_flag_q;
         if (hit_sta_w) begin
            rdata_q[mcuic_pkg::STAT_REQ_BIT]   <= req_w;
            rdata_q[mcuic_pkg::STAT_SLEEP_BIT] <= (pwr_q == mcuic_pkg::MCUIC_SLEEP);
            rdata_q[mcuic_pkg::STAT_ISR_BIT]   <= in_isr_q;
            rdata_q[mcuic_pkg::STAT_PINS_LSB +: 4] <= evt.port_now;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // vectoring: one pulse, pc push and vector load together
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_q    <= 1'b0;
         in_isr_q <= 1'b0;
      end else begin
         vec_q <= accept_w;
         if (accept_w) begin
            in_isr_q <= 1'b1;
         end else if (return_from_isr) begin
            in_isr_q <= 1'b0;
         end
      end
   end

   assign vector_load = vec_q;
   assign push_return = vec_q;
   assign vector_addr = vec_q ? mcuic_pkg::VECTOR_ADDR : '0;
   assign irq_request = req_w;

   ////////////////////////////////////////////////////////////////////////////
   // sleep and wake-up; pending at sleep entry makes the sleep a no-op
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_q  <= mcuic_pkg::MCUIC_RUN;
         wake_q <= 1'b0;
      end else begin
         wake_q <= 1'b0;
         unique case (pwr_q)
            mcuic_pkg::MCUIC_RUN: begin
               if (sleep_enter && !pending_w) begin
                  pwr_q <= mcuic_pkg::MCUIC_SLEEP;
               end
            end
            mcuic_pkg::MCUIC_SLEEP: begin
               if (pending_w) begin
                  pwr_q  <= mcuic_pkg::MCUIC_RUN;
                  wake_q <= 1'b1;
               end
            end
         endcase
      end
   end

   assign wake_up  = wake_q;
   assign sleeping = (pwr_q == mcuic_pkg::MCUIC_SLEEP);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_vec_clears_gie: assert property (vector_load |-> !gie_w)
      else $error("global enable still set on vector");
   a_vec_addr_push: assert property (vector_load |-> push_return && vector_addr == mcuic_pkg::VECTOR_ADDR)
      else $error("vector without push or wrong address");
   a_req_to_vector: assert property (irq_request && !sleeping && !vector_load |=> vector_load)
      else $error("accepted request did not vector");
   a_gie_off_quiet: assert property (!gie_w |-> !irq_request ##1 !vector_load)
      else $error("request with global enable clear");
   a_mask_quiet: assert property ((flags_w & enables_w) == 4'h0 |-> !irq_request)
      else $error("masked source requested");
   a_return_sets: assert property (return_from_isr && !accept_w |=> gie_w)
      else $error("return did not set global enable");
   a_flag_sticky: assert property (intctl_q[mcuic_pkg::EXT_FLAG_BIT] && !wr_int_w
                                   |=> intctl_q[mcuic_pkg::EXT_FLAG_BIT])
      else $error("pin flag dropped without software");
   a_edge_sets: assert property (evt.ext_edge |=> intctl_q[mcuic_pkg::EXT_FLAG_BIT])
      else $error("pin edge lost");
   a_timer_sets: assert property (timer_rollover |=> intctl_q[mcuic_pkg::TMR_FLAG_BIT])
      else $error("timer rollover lost");
   a_port_sets: assert property (evt.port_change |=> intctl_q[mcuic_pkg::PORT_FLAG_BIT])
      else $error("port change lost");
   a_nvm_sets: assert property (nvm_write_done |=> nvm_flag_q)
      else $error("nvm completion lost");
   a_pin_latency: assert property (evt.ext_edge && gie_w && intctl_q[mcuic_pkg::EXT_EN_BIT] && !sleeping
                                   |-> ##[1:2] vector_load)
      else $error("pin latency too long");
   a_wake_now: assert property (sleeping && pending_w |=> wake_up && !sleeping)
      else $error("enabled source did not wake");
   a_no_wake_masked: assert property (sleeping && !pending_w |=> !wake_up)
      else $error("wake without enabled flag");

   // pulse shapes, stickiness of the other flags and sleep side cases
   a_vec_one_pulse: assert property (vector_load |=> !vector_load)
      else $error("vector pulse longer than one cycle");
   a_no_double_vec: assert property (vector_load |-> !accept_w)
      else $error("second accept during vector");
   a_vec_addr_idle: assert property (!vector_load |-> vector_addr == '0)
      else $error("vector address shown without vector");
   a_wake_pulse: assert property (wake_up |=> !wake_up)
      else $error("wake pulse longer than one cycle");
   a_port_sticky: assert property (intctl_q[mcuic_pkg::PORT_FLAG_BIT] && !wr_int_w
                                   |=> intctl_q[mcuic_pkg::PORT_FLAG_BIT])
      else $error("port flag dropped without software");
   a_tmr_sticky: assert property (intctl_q[mcuic_pkg::TMR_FLAG_BIT] && !wr_int_w
                                  |=> intctl_q[mcuic_pkg::TMR_FLAG_BIT])
      else $error("timer flag dropped without software");
   a_nvm_sticky: assert property (nvm_flag_q && !wr_nvm_w |=> nvm_flag_q)
      else $error("nvm flag dropped without software");
   a_masked_no_vec: assert property (!pending_w |=> !vector_load)
      else $error("vector without enabled flag");
   a_sleep_noop: assert property (!sleeping && sleep_enter && pending_w |=> !sleeping)
      else $error("sleep entered with enabled flag pending");
   a_no_vec_asleep: assert property (sleeping |=> !vector_load)
      else $error("vector taken while asleep");
   a_isr_on_entry: assert property (vector_load |-> in_isr_q)
      else $error("in-isr status not set on vector");
   a_ret_leaves_isr: assert property (return_from_isr && !accept_w |=> !in_isr_q)
      else $error("in-isr status kept after return");
   a_option_write: assert property (wr_opt_w |=> option_q == $past(pwdata[7:0]))
      else $error("option write lost");

   c_vector: cover property (vector_load ##[1:20] return_from_isr);
   c_wake_gie_off: cover property (sleeping ##1 wake_up && !gie_w);
   c_wake_then_vector: cover property (wake_up ##1 vector_load);
   c_set_beats_clear: cover property (wr_int_w && evt.ext_edge);
   c_sleep_noop: cover property (sleep_enter && pending_w && !sleeping);
endmodule // mcuic_top
`default_nettype wire
